// ===== oscctl_top.sv
// oscillator control and status registers with an axi4-lite slave
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
// How it works
// - stable flag needs stable and requested oscillator
// - run-in-standby alone leaves stable flag low
// - switching flag high until new source stable
// - run-in-standby keeps internal oscillator powered
// - no internal clock output without a request
// - gate opens four ticks after analog ready, or four ticks after request in run-in-standby
// - six-bit frequency trim, fuse-selected reset value
// - four-bit temperature slope trim, fuse reset value
// - fuse lock bit blocks both trim writes
// - crystal setup fields frozen while enabled or stable
// - start-up field picks 1k/16k/32k/64k ticks
// - external clock mode skips crystal start-up wait
// - source select: crystal or external clock
// - crystal runs always or on request when enabled
// - crystal output only reaches active requesters
// - warm crystal reaches new requester in two ticks
// - crystal enable takes pins, freezes setup fields
// - crystal enable and standby need protected write
// - external clock start-up is two ticks
module oscctl_top
  import oscctl_pkg::*;
#(
  parameter logic [5:0] FRC_TRIM_16M = 6'h20,
  parameter logic [5:0] FRC_TRIM_20M = 6'h20,
  parameter logic [3:0] FRC_TEMP_16M = 4'h8,
  parameter logic [3:0] FRC_TEMP_20M = 4'h8
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              fast_rc_tick,
  input  wire logic              lp_rc_tick,
  input  wire logic              crystal_tick,
  input  wire logic              fast_rc_analog_ready,
  input  wire logic              lp_rc_analog_ready,
  input  wire logic              fast_rc_periph_req,
  input  wire logic              lp_rc_periph_req,
  input  wire logic              crystal_periph_req,
  input  wire logic [1:0]        main_clock_select,
  input  wire logic              ext_clock_stable,
  input  wire logic              fuse_frequency_select,
  input  wire logic              fuse_calibration_lock,
  output logic                   fast_rc_power,
  output logic                   fast_rc_clk_gate,
  output logic                   lp_rc_power,
  output logic                   lp_rc_clk_gate,
  output logic                   crystal_power,
  output logic                   crystal_clk_gate,
  output logic                   crystal_pin_override,
  output logic                   crystal_ext_clock_mode,
  output logic [5:0]             fast_rc_freq_trim_field,
  output logic [3:0]             fast_rc_temp_slope_trim,
  output logic [1:0]             main_clock_active
);
  logic              aw_full_q;
  logic              w_full_q;
  logic [5:0]        wr_idx_q;
  logic [31:0]       wdata_q;
  logic              wstrb0_q;
  logic              wr_fire;
  logic              wr_byte;
  logic [5:0]        rd_idx;
  logic [7:0]        rd_byte;
  logic              rd_hit;
  logic              wr_hit;
  logic [2:0]        prot_cnt_q;
  logic              prot_open;
  logic              frc_stby_q;
  logic              lp_stby_q;
  logic              xo_en_q;
  logic              xo_stby_q;
  logic              xo_sel_q;
  logic [1:0]        xo_su_q;
  logic              lock_q;
  logic [1:0]        cur_main_q;
  logic              frc_req;
  logic              lp_req;
  logic              xo_req;
  logic              src_stable;
  logic              switching;
  logic [7:0]        status;

  assign wr_fire   = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign wr_byte   = wr_fire & wstrb0_q;
  assign prot_open = (prot_cnt_q != 3'h0);

  always_comb
  begin
    case (wr_idx_q)
      IDX_FRC_CTRL, IDX_FRC_TRIM, IDX_FRC_TEMP, IDX_LPRC_CTRL,
      IDX_XTAL_CTRL, IDX_STATUS, IDX_PROT_KEY:
        wr_hit = 1'b1;
      default:
        wr_hit = 1'b0;
    endcase
  end

  // write address and data may arrive in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q     <= 1'b0;
      s_axi_awready <= 1'b1;
      wr_idx_q      <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_q     <= 1'b1;
      s_axi_awready <= 1'b0;
      wr_idx_q      <= s_axi_awaddr[ADDR_W-1:2];
    end
    else if (wr_fire)
      aw_full_q <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_awready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_q     <= 1'b0;
      s_axi_wready <= 1'b1;
      wdata_q      <= '0;
      wstrb0_q     <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_q     <= 1'b1;
      s_axi_wready <= 1'b0;
      wdata_q      <= s_axi_wdata;
      wstrb0_q     <= s_axi_wstrb[0];
    end
    else if (wr_fire)
      w_full_q <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_wready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // the window counts bus writes, standing in for cpu instructions
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prot_cnt_q <= '0;
    else if (wr_byte && wr_idx_q == IDX_PROT_KEY && wdata_q[7:0] == PROT_KEY)
      prot_cnt_q <= PROT_WINDOW;
    else if (wr_fire && prot_open)
      prot_cnt_q <= prot_cnt_q - 3'h1;
  end

  // internal rc control registers, protected
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      frc_stby_q <= 1'b0;
      lp_stby_q  <= 1'b0;
    end
    else if (wr_byte && prot_open)
    begin
      if (wr_idx_q == IDX_FRC_CTRL)
        frc_stby_q <= wdata_q[RUNSTBY_BIT];
      if (wr_idx_q == IDX_LPRC_CTRL)
        lp_stby_q <= wdata_q[RUNSTBY_BIT];
    end
  end

  // trims load from fuses while reset is held; lock is read-only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lock_q                  <= fuse_calibration_lock;
      fast_rc_freq_trim_field <= fuse_frequency_select ? FRC_TRIM_20M
                                                       : FRC_TRIM_16M;
      fast_rc_temp_slope_trim <= fuse_frequency_select ? FRC_TEMP_20M
                                                       : FRC_TEMP_16M;
    end
    else if (wr_byte && prot_open && !lock_q)
    begin
      if (wr_idx_q == IDX_FRC_TRIM)
        fast_rc_freq_trim_field <= wdata_q[FREQ_TRIM_W-1:0];
      if (wr_idx_q == IDX_FRC_TEMP)
        fast_rc_temp_slope_trim <= wdata_q[TEMP_TRIM_W-1:0];
    end
  end

  // crystal control: enable and standby protected, setup fields frozen
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      xo_en_q   <= 1'b0;
      xo_stby_q <= 1'b0;
      xo_sel_q  <= 1'b0;
      xo_su_q   <= '0;
    end
    else if (wr_byte && prot_open && wr_idx_q == IDX_XTAL_CTRL)
    begin
      xo_en_q   <= wdata_q[ENABLE_BIT];
      xo_stby_q <= wdata_q[RUNSTBY_BIT];
      if (!xo_en_q && !crystal_clk_gate)
      begin
        xo_sel_q  <= wdata_q[SEL_BIT];
        xo_su_q   <= wdata_q[SU_LSB+1:SU_LSB];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      crystal_pin_override   <= 1'b0;
      crystal_ext_clock_mode <= 1'b0;
    end
    else
    begin
      crystal_pin_override   <= xo_en_q;
      crystal_ext_clock_mode <= xo_en_q & xo_sel_q;
    end
  end

  // the old source stays requested until the new one is stable
  assign frc_req = fast_rc_periph_req | (cur_main_q == SRC_FRC)
                   | (main_clock_select == SRC_FRC);
  assign lp_req  = lp_rc_periph_req | (cur_main_q == SRC_LPRC)
                   | (main_clock_select == SRC_LPRC);
  assign xo_req  = crystal_periph_req | (cur_main_q == SRC_XTAL)
                   | (main_clock_select == SRC_XTAL);

  oscctl_rc_gate u_frc
  (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .osc_tick     (fast_rc_tick),
    .request      (frc_req),
    .run_stby     (frc_stby_q),
    .analog_ready (fast_rc_analog_ready),
    .power_q      (fast_rc_power),
    .gate_q       (fast_rc_clk_gate)
  );

  oscctl_rc_gate u_lprc
  (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .osc_tick     (lp_rc_tick),
    .request      (lp_req),
    .run_stby     (lp_stby_q),
    .analog_ready (lp_rc_analog_ready),
    .power_q      (lp_rc_power),
    .gate_q       (lp_rc_clk_gate)
  );

  oscctl_xtal_start u_xtal
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .xtal_tick (crystal_tick),
    .enable    (xo_en_q),
    .run_stby  (xo_stby_q),
    .request   (xo_req),
    .sel       (xo_sel_q),
    .su_sel    (xo_su_q),
    .power_q   (crystal_power),
    .gate_q    (crystal_clk_gate)
  );

  always_comb
  begin
    case (main_clock_select)
      SRC_FRC:  src_stable = fast_rc_clk_gate;
      SRC_LPRC: src_stable = lp_rc_clk_gate;
      SRC_XTAL: src_stable = crystal_clk_gate;
      default:  src_stable = ext_clock_stable;
    endcase
  end

  assign switching = (main_clock_select != cur_main_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cur_main_q <= SRC_FRC;
    else if (switching && src_stable)
      cur_main_q <= main_clock_select;
  end

  assign main_clock_active = cur_main_q;

  // gate outputs are open only while requested and stable
  always_comb
  begin
    status                 = '0;
    status[SWITCH_BIT]     = switching;
    status[FRC_STABLE_BIT] = fast_rc_clk_gate;
    status[LP_STABLE_BIT]  = lp_rc_clk_gate;
    status[XO_STABLE_BIT]  = crystal_clk_gate;
  end

  assign rd_idx = s_axi_araddr[ADDR_W-1:2];

  // unlisted bits read zero and status ignores writes
  always_comb
  begin
    rd_byte = '0;
    rd_hit  = 1'b1;
    case (rd_idx)
      IDX_STATUS:    rd_byte = status;
      IDX_FRC_CTRL:  rd_byte[RUNSTBY_BIT] = frc_stby_q;
      IDX_FRC_TRIM:  rd_byte[FREQ_TRIM_W-1:0] = fast_rc_freq_trim_field;
      IDX_FRC_TEMP:
      begin
        rd_byte[TEMP_TRIM_W-1:0] = fast_rc_temp_slope_trim;
        rd_byte[LOCK_BIT]        = lock_q;
      end
      IDX_LPRC_CTRL: rd_byte[RUNSTBY_BIT] = lp_stby_q;
      IDX_XTAL_CTRL:
      begin
        rd_byte[ENABLE_BIT]              = xo_en_q;
        rd_byte[RUNSTBY_BIT]             = xo_stby_q;
        rd_byte[SEL_BIT]                 = xo_sel_q;
        rd_byte[SU_LSB+1:SU_LSB]         = xo_su_q;
      end
      IDX_PROT_KEY:  rd_byte = '0;
      default:       rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_byte};
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : oscctl_top

// ===== oscctl_pkg.sv
// constants and types shared by the oscillator control block
package oscctl_pkg;
  localparam int          ADDR_W         = 8;
  localparam logic [5:0]  IDX_STATUS     = 6'h03;
  localparam logic [5:0]  IDX_FRC_CTRL   = 6'h10;
  localparam logic [5:0]  IDX_FRC_TRIM   = 6'h11;
  localparam logic [5:0]  IDX_FRC_TEMP   = 6'h12;
  localparam logic [5:0]  IDX_LPRC_CTRL  = 6'h18;
  localparam logic [5:0]  IDX_XTAL_CTRL  = 6'h1c;
  localparam logic [5:0]  IDX_PROT_KEY   = 6'h20;
  localparam int          ENABLE_BIT     = 0;
  localparam int          RUNSTBY_BIT    = 1;
  localparam int          SEL_BIT        = 2;
  localparam int          SU_LSB         = 4;
  localparam int          LOCK_BIT       = 7;
  localparam int          SWITCH_BIT     = 0;
  localparam int          FRC_STABLE_BIT = 4;
  localparam int          LP_STABLE_BIT  = 5;
  localparam int          XO_STABLE_BIT  = 6;
  localparam int          FREQ_TRIM_W    = 6;
  localparam int          TEMP_TRIM_W    = 4;
  localparam logic [7:0]  PROT_KEY       = 8'ha5;
  localparam logic [2:0]  PROT_WINDOW    = 3'h4;
  localparam logic [2:0]  GATE_TICKS     = 3'h4;
  localparam logic [16:0] XO_SU_1K       = 17'h0_0400;
  localparam logic [16:0] XO_SU_16K      = 17'h0_4000;
  localparam logic [16:0] XO_SU_32K      = 17'h0_8000;
  localparam logic [16:0] XO_SU_64K      = 17'h1_0000;
  localparam logic [16:0] XO_SU_EXT      = 17'h0_0002;
  localparam logic [16:0] XO_REOPEN      = 17'h0_0002;
  localparam logic [1:0]  SRC_FRC        = 2'h0;
  localparam logic [1:0]  SRC_LPRC       = 2'h1;
  localparam logic [1:0]  SRC_XTAL       = 2'h2;
  localparam logic [1:0]  SRC_EXT        = 2'h3;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  typedef enum logic [1:0] {
    RC_OFF = 2'b00, RC_ANALOG = 2'b01, RC_GATE = 2'b11, RC_OPEN = 2'b10
  } oscctl_rc_state_type;
  typedef enum logic [1:0] {
    XO_OFF = 2'b00, XO_WARM = 2'b01, XO_READY = 2'b11, XO_OPEN = 2'b10
  } oscctl_xo_state_type;
endpackage : oscctl_pkg

// ===== oscctl_rc_gate.sv
// start-up and clock gate sequencer for one internal rc oscillator
`timescale 1ns/1ns
module oscctl_rc_gate
  import oscctl_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic osc_tick,
  input  wire logic request,
  input  wire logic run_stby,
  input  wire logic analog_ready,
  output logic      power_q,
  output logic      gate_q
);
  oscctl_rc_state_type state_q;
  oscctl_rc_state_type state_d;
  logic [2:0]          cnt_q;
  logic [2:0]          cnt_d;

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      RC_OFF:
      begin
        cnt_d = '0;
        // already powered by run-in-standby: no analog wait
        if (request)
          state_d = run_stby ? RC_GATE : RC_ANALOG;
      end
      RC_ANALOG:
      begin
        if (!request)
          state_d = RC_OFF;
        else if (analog_ready)
          state_d = RC_GATE;
      end
      RC_GATE:
      begin
        if (!request)
          state_d = RC_OFF;
        else if (osc_tick)
        begin
          cnt_d = cnt_q + 3'h1;
          if (cnt_d == GATE_TICKS)
            state_d = RC_OPEN;
        end
      end
      RC_OPEN:
      begin
        if (!request)
          state_d = RC_OFF;
      end
      default:
        state_d = RC_OFF;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= RC_OFF;
      cnt_q   <= '0;
      power_q <= 1'b0;
      gate_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      power_q <= run_stby | request;
      gate_q  <= (state_d == RC_OPEN);
    end
  end
endmodule : oscctl_rc_gate

// ===== oscctl_xtal_start.sv
// start-up counter and output gate for the 32 khz crystal oscillator
`timescale 1ns/1ns
module oscctl_xtal_start
  import oscctl_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       xtal_tick,
  input  wire logic       enable,
  input  wire logic       run_stby,
  input  wire logic       request,
  input  wire logic       sel,
  input  wire logic [1:0] su_sel,
  output logic            power_q,
  output logic            gate_q
);
  oscctl_xo_state_type state_q;
  oscctl_xo_state_type state_d;
  logic [16:0]         cnt_q;
  logic [16:0]         cnt_d;
  logic [16:0]         limit;
  logic                powered;

  assign powered = enable & (run_stby | request);

  always_comb
  begin
    case (su_sel)
      2'h0:    limit = XO_SU_1K;
      2'h1:    limit = XO_SU_16K;
      2'h2:    limit = XO_SU_32K;
      default: limit = XO_SU_64K;
    endcase
    if (sel)
      limit = XO_SU_EXT;
  end

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      XO_OFF:
      begin
        cnt_d = '0;
        if (powered)
          state_d = XO_WARM;
      end
      XO_WARM:
      begin
        if (!powered)
          state_d = XO_OFF;
        else if (xtal_tick)
        begin
          cnt_d = cnt_q + 17'h0_0001;
          if (cnt_d == limit)
          begin
            state_d = XO_READY;
            cnt_d   = '0;
          end
        end
      end
      XO_READY:
      begin
        // warm and running; a new requester waits two crystal ticks
        if (!powered)
          state_d = XO_OFF;
        else if (request && xtal_tick)
        begin
          cnt_d = cnt_q + 17'h0_0001;
          if (cnt_d == XO_REOPEN)
            state_d = XO_OPEN;
        end
        // a part count must not shorten the next request's wait
        else if (!request)
          cnt_d = '0;
      end
      XO_OPEN:
      begin
        if (!powered)
          state_d = XO_OFF;
        else if (!request)
        begin
          state_d = XO_READY;
          cnt_d   = '0;
        end
      end
      default:
        state_d = XO_OFF;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= XO_OFF;
      cnt_q   <= '0;
      power_q <= 1'b0;
      gate_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      power_q <= powered;
      gate_q  <= (state_d == XO_OPEN);
    end
  end
endmodule : oscctl_xtal_start

// ===== oscctl_properties.sv
// concurrent checks on the ports of the oscillator control block
`timescale 1ns/1ns
module oscctl_properties
  import oscctl_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        lp_rc_periph_req,
  input wire logic        lp_rc_clk_gate,
  input wire logic        crystal_periph_req,
  input wire logic        crystal_clk_gate,
  input wire logic        crystal_power,
  input wire logic        crystal_pin_override,
  input wire logic        fuse_calibration_lock,
  input wire logic [5:0]  fast_rc_freq_trim_field,
  input wire logic [3:0]  fast_rc_temp_slope_trim,
  input wire logic [1:0]  main_clock_select,
  input wire logic [1:0]  main_clock_active
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a gate may lag its request by one cycle when closing
  lp_gate_req_a: assert property (
    lp_rc_clk_gate |-> $past(lp_rc_periph_req || main_clock_select == SRC_LPRC
      || main_clock_active == SRC_LPRC)) else $error("lp gate open unrequested");
  xtal_gate_req_a: assert property (
    crystal_clk_gate |-> $past(crystal_periph_req || main_clock_select == SRC_XTAL
      || main_clock_active == SRC_XTAL)) else $error("crystal gate open unrequested");
  xtal_power_en_a: assert property (
    crystal_power |-> crystal_pin_override) else $error("crystal runs while disabled");
  lp_gate_delay_a: assert property (
    $rose(lp_rc_periph_req) && !lp_rc_clk_gate && main_clock_select != SRC_LPRC
      && main_clock_active != SRC_LPRC |-> !lp_rc_clk_gate [*4])
    else $error("lp gate opened early");
  trim_lock_a: assert property (
    fuse_calibration_lock && $past(fuse_calibration_lock) |-> $stable(fast_rc_freq_trim_field)
      && $stable(fast_rc_temp_slope_trim)) else $error("locked trim moved");
  switch_target_a: assert property (
    $changed(main_clock_active) |-> main_clock_active == $past(main_clock_select))
    else $error("main clock moved to unselected source");
  rdata_upper_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("upper read bits set");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule : oscctl_properties

bind oscctl_top oscctl_properties chk_i (.*);

// ===== oscillator_control_status_tb.sv
// self-checking bench for the oscillator control block
`timescale 1ns/1ns
module oscillator_control_status_tb;
  import oscctl_pkg::*;
  logic        aclk = 0, aresetn = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, rv;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, fast_rc_tick = 1, lp_rc_tick = 1, crystal_tick = 1;
  logic        fast_rc_analog_ready = 0, lp_rc_analog_ready = 1, ext_clock_stable = 1;
  logic        fast_rc_periph_req = 0, lp_rc_periph_req = 0, crystal_periph_req = 0;
  logic        fuse_frequency_select = 0, fuse_calibration_lock = 0, fast_rc_power;
  logic        fast_rc_clk_gate, lp_rc_power, lp_rc_clk_gate, crystal_power, crystal_clk_gate;
  logic        crystal_pin_override, crystal_ext_clock_mode;
  logic [1:0]  s_axi_bresp, s_axi_rresp, main_clock_select = 0, main_clock_active, rs;
  logic [5:0]  fast_rc_freq_trim_field;
  logic [3:0]  fast_rc_temp_slope_trim;
  int          error_cnt = 0, total_checks = 0, cyc = 0, n;
  // address, write data, read back, response
  logic [25:0] rows [8] = '{
    {8'h40, 8'hff, 8'h02, 2'h0}, {8'h60, 8'hff, 8'h02, 2'h0},
    {8'h44, 8'hff, 8'h3f, 2'h0}, {8'h48, 8'hff, 8'h0f, 2'h0},
    {8'h70, 8'hfe, 8'h36, 2'h0}, {8'h70, 8'h10, 8'h10, 2'h0},
    {8'h70, 8'h00, 8'h00, 2'h0}, {8'h14, 8'hff, 8'h00, 2'h2}};

  oscctl_top #(.FRC_TRIM_16M(6'h15), .FRC_TRIM_20M(6'h2a), .FRC_TEMP_16M(4'h3),
    .FRC_TEMP_20M(4'hc)) DUT (.*);

  initial
  begin
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task report_and_stop;
    $display("checks %0d bad %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task ck(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : ck

  // each channel is released at the edge that takes it; bready comes late
  // so that a waiting response is held for a cycle
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid === 1) s_axi_bready <= 1;
    end while (s_axi_bvalid !== 1 || s_axi_bready !== 1);
    rs = s_axi_bresp;
    s_axi_bready <= 0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1);
    rv = s_axi_rdata[7:0];
    rs = s_axi_rresp;
    s_axi_rready <= 0;
  endtask : rd

  function automatic logic pick(input int s);
    return s == 0 ? lp_rc_clk_gate : s == 1 ? crystal_clk_gate : fast_rc_clk_gate;
  endfunction : pick

  // counts edges until the chosen gate shows v
  task wg(input int s, input logic v);
    n = 0;
    while (pick(s) !== v && n < 2000)
    begin
      @(posedge aclk);
      n++;
    end
  endtask : wg

  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(8'h44);
    ck(rv, 8'h15);
    rd(8'h48);
    ck(rv, 8'h03);
    rd(8'h0c);
    ck(rv[4], 0);
    ck(fast_rc_power, 1);
    fast_rc_analog_ready <= 1;
    wg(2, 1);
    rd(8'h0c);
    ck(rv[4:0], 5'h10);
    // window allows four writes after the key
    wr(8'h80, PROT_KEY);
    repeat (4) wr(8'h0c, 8'hff);
    wr(8'h70, 8'h03);
    rd(8'h70);
    ck(rv, 8'h00);
    $display("reset and protection done");
    foreach (rows[i])
    begin
      wr(8'h80, PROT_KEY);
      wr(rows[i][25:18], rows[i][17:10]);
      ck(rs, rows[i][1:0]);
      rd(rows[i][25:18]);
      ck(rv, rows[i][9:2]);
      ck(rs, rows[i][1:0]);
    end
    $display("table done");
    lp_rc_analog_ready <= 0;
    ck(lp_rc_power, 1);
    ck(lp_rc_clk_gate, 0);
    rd(8'h0c);
    ck(rv[5], 0);
    lp_rc_periph_req <= 1;
    wg(0, 1);
    ck(n >= 4 && n <= 8, 1);
    rd(8'h0c);
    ck(rv[5], 1);
    lp_rc_periph_req <= 0;
    wg(0, 0);
    ck(n <= 3, 1);
    wr(8'h80, PROT_KEY);
    wr(8'h60, 8'h00);
    repeat (2) @(posedge aclk);
    ck(lp_rc_power, 0);
    main_clock_select <= SRC_LPRC;
    rd(8'h0c);
    ck(rv[0], 1);
    lp_rc_analog_ready <= 1;
    wg(0, 1);
    repeat (2) @(posedge aclk);
    ck(main_clock_active, SRC_LPRC);
    rd(8'h0c);
    ck(rv[0], 0);
    wg(2, 0);
    fast_rc_periph_req <= 1;
    wg(2, 1);
    ck(n >= 4 && n <= 8, 1);
    $display("rc oscillators done");
    wr(8'h80, PROT_KEY);
    wr(8'h70, 8'h03);
    crystal_periph_req <= 1;
    wg(1, 1);
    ck(n >= 1020 && n <= 1040, 1);
    ck(crystal_pin_override, 1);
    wr(8'h80, PROT_KEY);
    wr(8'h70, 8'h37);
    rd(8'h70);
    ck(rv, 8'h03);
    crystal_periph_req <= 0;
    wg(1, 0);
    ck(crystal_power, 1);
    crystal_periph_req <= 1;
    wg(1, 1);
    ck(n <= 5, 1);
    wr(8'h80, PROT_KEY);
    wr(8'h70, 8'h00);
    n = 0;
    do
    begin
      rd(8'h0c);
      n++;
    end while (rv[6] !== 0 && n < 20);
    ck(rv[6], 0);
    wr(8'h80, PROT_KEY);
    wr(8'h70, 8'h07);
    wg(1, 1);
    ck(n <= 10, 1);
    ck(crystal_ext_clock_mode, 1);
    $display("crystal done");
    aresetn <= 0;
    fuse_frequency_select <= 1;
    fuse_calibration_lock <= 1;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    wr(8'h80, PROT_KEY);
    wr(8'h44, 8'h01);
    wr(8'h48, 8'h01);
    rd(8'h44);
    ck(rv, 8'h2a);
    rd(8'h48);
    ck(rv, 8'h8c);
    ck(fast_rc_freq_trim_field, 6'h2a);
    ck(fast_rc_temp_slope_trim, 4'hc);
    $display("fuse reset done");
    // switch to the external source only once it reports started
    ext_clock_stable <= 0;
    main_clock_select <= SRC_EXT;
    repeat (3) @(posedge aclk);
    ck(main_clock_active, SRC_LPRC);
    ext_clock_stable <= 1;
    repeat (3) @(posedge aclk);
    ck(main_clock_active, SRC_EXT);
    $display("external switch done");
    report_and_stop();
  end
endmodule : oscillator_control_status_tb
